// ===== hdl/ppfm_pkg.sv
// constants for the port pin function mux: register map, reset values, selects
// assumes a 32-bit apb slave with byte strobes
package ppfm_pkg;
  localparam int P7_W = 8;
  localparam int P8_W = 2;
  localparam int P9_W = 16;
  localparam int NPIN = P7_W + P8_W + P9_W;

  // register byte offsets
  localparam logic [7:0] OFS_P7_DATA    = 8'h00;
  localparam logic [7:0] OFS_P7_DIR     = 8'h04;
  localparam logic [7:0] OFS_P8_DATA    = 8'h08;
  localparam logic [7:0] OFS_P8_DIR     = 8'h0C;
  localparam logic [7:0] OFS_P8_MODE    = 8'h10;
  localparam logic [7:0] OFS_P8_OD      = 8'h14;
  localparam logic [7:0] OFS_P9_DATA    = 8'h20;
  localparam logic [7:0] OFS_P9_DATA_H  = 8'h24;
  localparam logic [7:0] OFS_P9_DIR     = 8'h28;
  localparam logic [7:0] OFS_P9_DIR_H   = 8'h2C;
  localparam logic [7:0] OFS_P9_MODE    = 8'h30;
  localparam logic [7:0] OFS_P9_MODE_H  = 8'h34;
  localparam logic [7:0] OFS_P9_FSEL    = 8'h38;
  localparam logic [7:0] OFS_P9_FSEL_H  = 8'h3C;
  localparam logic [7:0] OFS_P9_XSEL    = 8'h40;
  localparam logic [7:0] OFS_P9_XSEL_H  = 8'h44;
  localparam logic [7:0] OFS_P9_OD      = 8'h48;
  localparam logic [7:0] OFS_P9_OD_H    = 8'h4C;
  localparam logic [7:0] OFS_STATUS     = 8'h50;

  // reset values: ports come up as inputs in port mode
  localparam logic [P7_W-1:0] RST_P7_DIR  = 8'hFF;
  localparam logic [P8_W-1:0] RST_P8_DIR  = 2'h3;
  localparam logic [P9_W-1:0] RST_P9_DIR  = 16'hFFFF;
  localparam logic [P9_W-1:0] RST_ZERO16  = 16'h0000;
  localparam logic [P9_W-1:0] P9_ALL_ALT  = 16'hFFFF;

  // status register field
  localparam int ST_ADDR_BUS_BIT = 0;

  // port 9 alternate select {ext_function_select, function_select}
  localparam logic [1:0] SEL_ADDR_BUS = 2'b00;
  localparam logic [1:0] SEL_KEY_RET  = 2'b01;
  localparam logic [1:0] SEL_UART1_RX = 2'b10;
  localparam logic [1:0] SEL_PERIPH   = 2'b11;

  // shared pin positions
  localparam int P8_SHARED_PIN = 0;
  localparam int P9_RX_KR_PIN  = 1;
endpackage

// ===== hdl/ppfm_sync3.sv
// three-stage input synchroniser with agreement filter
// assumes asynchronous pin levels on the input
`timescale 1ns/1ns
module ppfm_sync3
  import ppfm_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_q
);
  logic [W-1:0] s1_q, s2_q, s3_q, sync_d;

  always_comb begin
    sync_d = sync_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        sync_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      sync_q <= '0;
    end else begin
      s1_q   <= async_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      sync_q <= sync_d;
    end
  end
endmodule

// ===== hdl/ppfm_pin_cell.sv
// one pin driver: port or alternate function, push-pull or open drain
// assumes control inputs come from registers on the same clock
`timescale 1ns/1ns
module ppfm_pin_cell
  import ppfm_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic latch,
  input  wire logic dir,
  input  wire logic mode,
  input  wire logic od,
  input  wire logic alt_out,
  input  wire logic alt_oe,
  output logic      pin_out_q,
  output logic      pin_oe_q
);
  logic drive, val, pin_out_d, pin_oe_d;

  always_comb begin
    drive     = mode ? alt_oe : ~dir;
    val       = mode ? alt_out : latch;
    pin_oe_d  = drive & (od ? ~val : 1'b1);
    pin_out_d = od ? 1'b0 : val;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= 1'b0;
      pin_oe_q  <= 1'b0;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
    end
  end
endmodule

// ===== hdl/ppfm_top.sv
// port 7/8/9 pin function mux with apb register access
// assumes apb4 master on pclk; pins arrive asynchronously
`timescale 1ns/1ns
module ppfm_top
  import ppfm_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [P7_W-1:0]  p7_pin_in,
  output logic      [P7_W-1:0]  p7_pin_out,
  output logic      [P7_W-1:0]  p7_pin_oe,
  output logic      [P7_W-1:0]  analog_input_pin,
  input  wire logic [P8_W-1:0]  p8_pin_in,
  output logic      [P8_W-1:0]  p8_pin_out,
  output logic      [P8_W-1:0]  p8_pin_oe,
  output logic                  ext_irq8_pin,
  output logic                  uart3_rx_pin,
  input  wire logic [P9_W-1:0]  p9_pin_in,
  output logic      [P9_W-1:0]  p9_pin_out,
  output logic      [P9_W-1:0]  p9_pin_oe,
  input  wire logic [P9_W-1:0]  address_bus_lines,
  input  wire logic [P9_W-1:0]  p9_periph_out,
  input  wire logic [P9_W-1:0]  p9_periph_oe,
  output logic                  uart1_rx_pin,
  output logic                  key_return7_pin,
  output logic                  addr_bus_active
);
  logic [P7_W-1:0] p7_data_q, p7_data_d, p7_dir_q, p7_dir_d;
  logic [P8_W-1:0] p8_data_q, p8_data_d, p8_dir_q, p8_dir_d;
  logic [P8_W-1:0] p8_mode_q, p8_mode_d, p8_od_q, p8_od_d;
  logic [P9_W-1:0] p9_data_q, p9_data_d, p9_dir_q, p9_dir_d;
  logic [P9_W-1:0] p9_mode_q, p9_mode_d, p9_fsel_q, p9_fsel_d;
  logic [P9_W-1:0] p9_xsel_q, p9_xsel_d, p9_od_q, p9_od_d;
  logic [31:0]     prdata_d, rd_val;
  logic            pready_d, pslverr_d, hit, wr_en, setup;
  logic [P7_W-1:0] p7_s, p7_rd;
  logic [P8_W-1:0] p8_s, p8_rd;
  logic [P9_W-1:0] p9_s, p9_rd, p9_alt_out, p9_alt_oe;
  logic [NPIN-1:0] all_pin_in, all_latch, all_dir, all_mode, all_od;
  logic [NPIN-1:0] all_alt_out, all_alt_oe, all_pin_out, all_pin_oe;
  logic            irq8_d, irq8_q, urx3_d, urx3_q, urx1_d, urx1_q, kr7_d, kr7_q;
  logic            abus_d, abus_q;
  logic [P7_W-1:0] ana_d, ana_q;
  logic [1:0]      sel_rxkr;

  // merge a 16-bit register with a write using lanes 0 and 1
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // high alias: lane 0 of the bus lands on bits 15:8
  function automatic logic [15:0] wr16h(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[15:8] = wd[7:0];
    end
    return r;
  endfunction

  ppfm_sync3 #(.W(NPIN)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (all_pin_in),
    .sync_q   ({p9_s, p8_s, p7_s})
  );

  // data reads: latch for output pins, pin level for input pins
  always_comb begin
    p7_rd = (p7_dir_q & p7_s) | (~p7_dir_q & p7_data_q);
    p8_rd = (p8_dir_q & p8_s) | (~p8_dir_q & p8_data_q);
    p9_rd = (p9_dir_q & p9_s) | (~p9_dir_q & p9_data_q);
  end

  // register read decode
  always_comb begin
    rd_val = 32'h0000_0000;
    hit    = 1'b1;
    case (paddr)
      OFS_P7_DATA:   rd_val[P7_W-1:0] = p7_rd;
      OFS_P7_DIR:    rd_val[P7_W-1:0] = p7_dir_q;
      OFS_P8_DATA:   rd_val[P8_W-1:0] = p8_rd;
      OFS_P8_DIR:    rd_val[P8_W-1:0] = p8_dir_q;
      OFS_P8_MODE:   rd_val[P8_W-1:0] = p8_mode_q;
      OFS_P8_OD:     rd_val[P8_W-1:0] = p8_od_q;
      OFS_P9_DATA:   rd_val[15:0] = p9_rd;
      OFS_P9_DATA_H: rd_val[7:0]  = p9_rd[15:8];
      OFS_P9_DIR:    rd_val[15:0] = p9_dir_q;
      OFS_P9_DIR_H:  rd_val[7:0]  = p9_dir_q[15:8];
      OFS_P9_MODE:   rd_val[15:0] = p9_mode_q;
      OFS_P9_MODE_H: rd_val[7:0]  = p9_mode_q[15:8];
      OFS_P9_FSEL:   rd_val[15:0] = p9_fsel_q;
      OFS_P9_FSEL_H: rd_val[7:0]  = p9_fsel_q[15:8];
      OFS_P9_XSEL:   rd_val[15:0] = p9_xsel_q;
      OFS_P9_XSEL_H: rd_val[7:0]  = p9_xsel_q[15:8];
      OFS_P9_OD:     rd_val[15:0] = p9_od_q;
      OFS_P9_OD_H:   rd_val[7:0]  = p9_od_q[15:8];
      OFS_STATUS:    rd_val[ST_ADDR_BUS_BIT] = abus_q;
      default:       hit = 1'b0;
    endcase
  end

  // apb answer: one wait-free access, data registered in the setup cycle
  always_comb begin
    setup     = psel & ~penable;
    wr_en     = psel & penable & pready & pwrite & ~pslverr;
    pready_d  = setup;
    pslverr_d = setup & ~hit;
    prdata_d  = (setup & ~pwrite) ? rd_val : 32'h0000_0000;
  end

  // register writes
  always_comb begin
    p7_data_d = p7_data_q;
    p7_dir_d  = p7_dir_q;
    p8_data_d = p8_data_q;
    p8_dir_d  = p8_dir_q;
    p8_mode_d = p8_mode_q;
    p8_od_d   = p8_od_q;
    p9_data_d = p9_data_q;
    p9_dir_d  = p9_dir_q;
    p9_mode_d = p9_mode_q;
    p9_fsel_d = p9_fsel_q;
    p9_xsel_d = p9_xsel_q;
    p9_od_d   = p9_od_q;
    if (wr_en && pstrb[0]) begin
      case (paddr)
        OFS_P7_DATA: p7_data_d = pwdata[P7_W-1:0];
        OFS_P7_DIR:  p7_dir_d  = pwdata[P7_W-1:0];
        OFS_P8_DATA: p8_data_d = pwdata[P8_W-1:0];
        OFS_P8_DIR:  p8_dir_d  = pwdata[P8_W-1:0];
        OFS_P8_MODE: p8_mode_d = pwdata[P8_W-1:0];
        OFS_P8_OD:   p8_od_d   = pwdata[P8_W-1:0];
        default: begin
        end
      endcase
    end
    if (wr_en) begin
      case (paddr)
        OFS_P9_DATA:   p9_data_d = wr16(p9_data_q, pwdata, pstrb);
        OFS_P9_DATA_H: p9_data_d = wr16h(p9_data_q, pwdata, pstrb);
        OFS_P9_DIR:    p9_dir_d  = wr16(p9_dir_q, pwdata, pstrb);
        OFS_P9_DIR_H:  p9_dir_d  = wr16h(p9_dir_q, pwdata, pstrb);
        OFS_P9_MODE:   p9_mode_d = wr16(p9_mode_q, pwdata, pstrb);
        OFS_P9_MODE_H: p9_mode_d = wr16h(p9_mode_q, pwdata, pstrb);
        OFS_P9_FSEL:   p9_fsel_d = wr16(p9_fsel_q, pwdata, pstrb);
        OFS_P9_FSEL_H: p9_fsel_d = wr16h(p9_fsel_q, pwdata, pstrb);
        OFS_P9_XSEL:   p9_xsel_d = wr16(p9_xsel_q, pwdata, pstrb);
        OFS_P9_XSEL_H: p9_xsel_d = wr16h(p9_xsel_q, pwdata, pstrb);
        OFS_P9_OD:     p9_od_d   = wr16(p9_od_q, pwdata, pstrb);
        OFS_P9_OD_H:   p9_od_d   = wr16h(p9_od_q, pwdata, pstrb);
        default: begin
        end
      endcase
    end
  end

  // port 9 alternate outputs and peripheral inputs
  always_comb begin
    for (int i = 0; i < P9_W; i++) begin
      case ({p9_xsel_q[i], p9_fsel_q[i]})
        SEL_ADDR_BUS: begin
          p9_alt_out[i] = address_bus_lines[i];
          p9_alt_oe[i]  = 1'b1;
        end
        SEL_PERIPH: begin
          p9_alt_out[i] = p9_periph_out[i];
          p9_alt_oe[i]  = p9_periph_oe[i];
        end
        default: begin
          p9_alt_out[i] = 1'b0;
          p9_alt_oe[i]  = 1'b0;
        end
      endcase
    end
    sel_rxkr = {p9_xsel_q[P9_RX_KR_PIN], p9_fsel_q[P9_RX_KR_PIN]};
    // one pin, one select: receive and key return cannot both see it
    urx1_d = p9_mode_q[P9_RX_KR_PIN] & (sel_rxkr == SEL_UART1_RX)
             & p9_s[P9_RX_KR_PIN];
    kr7_d  = p9_mode_q[P9_RX_KR_PIN] & (sel_rxkr == SEL_KEY_RET)
             & p9_s[P9_RX_KR_PIN];
    // alternate inputs read low while the pin is in port mode
    irq8_d = p8_mode_q[P8_SHARED_PIN] & p8_s[P8_SHARED_PIN];
    urx3_d = p8_mode_q[P8_SHARED_PIN] & p8_s[P8_SHARED_PIN];
    abus_d = (p9_mode_q == P9_ALL_ALT) & (p9_fsel_q == RST_ZERO16)
             & (p9_xsel_q == RST_ZERO16);
    ana_d  = p7_dir_q;
  end

  assign all_pin_in  = {p9_pin_in, p8_pin_in, p7_pin_in};
  assign all_latch   = {p9_data_q, p8_data_q, p7_data_q};
  assign all_dir     = {p9_dir_q, p8_dir_q, p7_dir_q};
  assign all_mode    = {p9_mode_q, p8_mode_q, {P7_W{1'b0}}};
  assign all_od      = {p9_od_q, p8_od_q, {P7_W{1'b0}}};
  assign all_alt_out = {p9_alt_out, {(P8_W + P7_W){1'b0}}};
  assign all_alt_oe  = {p9_alt_oe, {(P8_W + P7_W){1'b0}}};

  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    ppfm_pin_cell u_cell (
      .pclk      (pclk),
      .presetn   (presetn),
      .latch     (all_latch[g]),
      .dir       (all_dir[g]),
      .mode      (all_mode[g]),
      .od        (all_od[g]),
      .alt_out   (all_alt_out[g]),
      .alt_oe    (all_alt_oe[g]),
      .pin_out_q (all_pin_out[g]),
      .pin_oe_q  (all_pin_oe[g])
    );
  end

  assign {p9_pin_out, p8_pin_out, p7_pin_out} = all_pin_out;
  assign {p9_pin_oe, p8_pin_oe, p7_pin_oe}    = all_pin_oe;
  assign ext_irq8_pin     = irq8_q;
  assign uart3_rx_pin     = urx3_q;
  assign uart1_rx_pin     = urx1_q;
  assign key_return7_pin  = kr7_q;
  assign addr_bus_active  = abus_q;
  assign analog_input_pin = ana_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p7_data_q <= '0;
      p7_dir_q  <= RST_P7_DIR;
      p8_data_q <= '0;
      p8_dir_q  <= RST_P8_DIR;
      p8_mode_q <= '0;
      p8_od_q   <= '0;
      p9_data_q <= RST_ZERO16;
      p9_dir_q  <= RST_P9_DIR;
      p9_mode_q <= RST_ZERO16;
      p9_fsel_q <= RST_ZERO16;
      p9_xsel_q <= RST_ZERO16;
      p9_od_q   <= RST_ZERO16;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      irq8_q    <= 1'b0;
      urx3_q    <= 1'b0;
      urx1_q    <= 1'b0;
      kr7_q     <= 1'b0;
      abus_q    <= 1'b0;
      ana_q     <= '0;
    end else begin
      p7_data_q <= p7_data_d;
      p7_dir_q  <= p7_dir_d;
      p8_data_q <= p8_data_d;
      p8_dir_q  <= p8_dir_d;
      p8_mode_q <= p8_mode_d;
      p8_od_q   <= p8_od_d;
      p9_data_q <= p9_data_d;
      p9_dir_q  <= p9_dir_d;
      p9_mode_q <= p9_mode_d;
      p9_fsel_q <= p9_fsel_d;
      p9_xsel_q <= p9_xsel_d;
      p9_od_q   <= p9_od_d;
      prdata    <= prdata_d;
      pready    <= pready_d;
      pslverr   <= pslverr_d;
      irq8_q    <= irq8_d;
      urx3_q    <= urx3_d;
      urx1_q    <= urx1_d;
      kr7_q     <= kr7_d;
      abus_q    <= abus_d;
      ana_q     <= ana_d;
    end
  end
endmodule

// ===== sim/ppfm_top_assertions.sv
// checker for the port pin function mux, bound to the top module's ports
// assumes a single pclk domain and asynchronous active-low presetn
`timescale 1ns/1ns
module ppfm_checker
  import ppfm_pkg::*;
(
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [P7_W-1:0]  p7_pin_oe,
  input wire logic [P7_W-1:0]  analog_input_pin,
  input wire logic             ext_irq8_pin,
  input wire logic             uart3_rx_pin,
  input wire logic [P9_W-1:0]  p9_pin_out,
  input wire logic [P9_W-1:0]  p9_pin_oe,
  input wire logic [P9_W-1:0]  address_bus_lines,
  input wire logic             uart1_rx_pin,
  input wire logic             key_return7_pin,
  input wire logic             addr_bus_active
);
  logic [2:0] up_q;
  logic [2:0] up_d;
  logic       is_alias;

  // cycles since reset release, saturating
  always_comb begin
    up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_q <= 3'h0;
    end else begin
      up_q <= up_d;
    end
  end

  assign is_alias = paddr inside {OFS_P9_DATA_H, OFS_P9_DIR_H, OFS_P9_MODE_H,
                                  OFS_P9_FSEL_H, OFS_P9_XSEL_H, OFS_P9_OD_H};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  setup_then_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_zero_a: assert property (!pready || pwrite |-> prdata == 32'h0000_0000)
    else $error("read data outside read access");
  alias_mapped_a: assert property (
    pready && is_alias |-> !pslverr)
    else $error("high alias refused");
  alias_upper_zero_a: assert property (
    pready && !pwrite && is_alias |-> prdata[31:8] == 24'h00_0000)
    else $error("high alias upper bits set");
  addr_bus_drive_a: assert property (up_q == 3'h7 && addr_bus_active
    && $past(addr_bus_active) |-> p9_pin_oe == 16'hFFFF
    && p9_pin_out == $past(address_bus_lines))
    else $error("address bus not on port 9 pins");
  shared_pin_same_a: assert property (uart3_rx_pin == ext_irq8_pin)
    else $error("shared port 8 routes differ");
  rx_kr_exclusive_a: assert property (!(uart1_rx_pin && key_return7_pin))
    else $error("uart1 and key return both routed");
  p7_drive_dir_a: assert property (up_q == 3'h7 && $stable(analog_input_pin)
    |-> p7_pin_oe == ~analog_input_pin)
    else $error("port 7 drive disagrees with direction");

  cover property (pready && pslverr);
  cover property (addr_bus_active);
  cover property (key_return7_pin);
  cover property (uart1_rx_pin);
endmodule

bind ppfm_top ppfm_checker i_ppfm_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .p7_pin_oe, .analog_input_pin, .ext_irq8_pin, .uart3_rx_pin,
  .p9_pin_out, .p9_pin_oe, .address_bus_lines, .uart1_rx_pin, .key_return7_pin,
  .addr_bus_active);

// ===== sim/test_port_pin_function_mux.sv
// self-checking bench for the port pin function mux over apb
// assumes ppfm_top and its bound checker; the bench drives all pins
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module test_port_pin_function_mux
  import ppfm_pkg::*;
;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0000_0000;
  logic [3:0]      pstrb = 4'h0;
  logic [P7_W-1:0] p7_pin_in = 8'h00;
  logic [P8_W-1:0] p8_pin_in = 2'h0;
  logic [P9_W-1:0] p9_pin_in = 16'h0000;
  logic [P9_W-1:0] address_bus_lines = 16'h0000;
  logic [P9_W-1:0] p9_periph_out = 16'h0000;
  logic [P9_W-1:0] p9_periph_oe = 16'h0000;
  logic [31:0]     prdata;
  logic            pready, pslverr, ext_irq8_pin, uart3_rx_pin;
  logic            uart1_rx_pin, key_return7_pin, addr_bus_active;
  logic [P7_W-1:0] p7_pin_out, p7_pin_oe, analog_input_pin;
  logic [P8_W-1:0] p8_pin_out, p8_pin_oe;
  logic [P9_W-1:0] p9_pin_out, p9_pin_oe;
  logic [31:0]     r;
  logic            e;
  logic [7:0]      ctl [5] = '{OFS_P9_DIR, OFS_P9_MODE, OFS_P9_FSEL, OFS_P9_XSEL, OFS_P9_OD};
  int              n_mismatch = 0;
  int              samples_checked = 0;

  ppfm_top i_ppfm_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .p7_pin_in, .p7_pin_out, .p7_pin_oe, .analog_input_pin,
    .p8_pin_in, .p8_pin_out, .p8_pin_oe, .ext_irq8_pin, .uart3_rx_pin, .p9_pin_in,
    .p9_pin_out, .p9_pin_oe, .address_bus_lines, .p9_periph_out, .p9_periph_oe,
    .uart1_rx_pin, .key_return7_pin, .addr_bus_active);

  always #5 pclk = ~pclk;

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_mismatch++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic [31:0] x;
    logic        y;
    xfer(a, 1'b1, d, s, x, y);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] x;
    logic        y;
    xfer(a, 1'b0, 32'h0000_0000, 4'h0, x, y);
    `CHK($sformatf("read %h", a), ex, x)
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(OFS_P7_DIR, 32'h0000_00FF);
    rd_chk(OFS_P8_DIR, 32'h0000_0003);
    rd_chk(OFS_P9_DIR_H, 32'h0000_00FF);
    rd_chk(OFS_STATUS, 32'h0000_0000);
    foreach (ctl[i]) begin
      wr(ctl[i], 32'h0000_A53C);
      rd_chk(ctl[i] + 8'h04, 32'h0000_00A5);
      wr(ctl[i] + 8'h04, 32'h0000_0069, 4'h1);
      wr(ctl[i] + 8'h04, 32'h0000_FF00, 4'h2);
      rd_chk(ctl[i], 32'h0000_693C);
      wr(ctl[i], (i == 0) ? 32'h0000_FFFF : 32'h0000_0000);
    end
    // port 9 data: latch when output, pin when input
    p9_pin_in <= 16'h0F0F;
    wr(OFS_P9_DIR, 32'h0000_0000);
    wr(OFS_P9_DATA, 32'h0000_C35A);
    wr(OFS_P9_DATA_H, 32'h0000_0081, 4'h1);
    rd_chk(OFS_P9_DATA, 32'h0000_815A);
    rd_chk(OFS_P9_DATA_H, 32'h0000_0081);
    `CHK("p9 oe", 16'hFFFF, p9_pin_oe)
    `CHK("p9 out", 16'h815A, p9_pin_out)
    wr(OFS_P9_DIR, 32'h0000_FFFF);
    wr(OFS_P9_DATA, 32'h0000_1111);
    rd_chk(OFS_P9_DATA, 32'h0000_0F0F);
    rd_chk(OFS_P9_DATA_H, 32'h0000_000F);
    wr(OFS_P9_DIR, 32'h0000_0000);
    rd_chk(OFS_P9_DATA, 32'h0000_1111);
    wr(OFS_P9_OD, 32'h0000_FFFF);
    repeat (2) @(posedge pclk);
    `CHK("p9 od oe", 16'hEEEE, p9_pin_oe)
    `CHK("p9 od out", 16'h0000, p9_pin_out)
    wr(OFS_P9_OD, 32'h0000_0000);
    wr(OFS_P9_DIR, 32'h0000_FFFF);
    // port 7 split between analog inputs and driven outputs
    wr(OFS_P7_DIR, 32'h0000_000F);
    wr(OFS_P7_DATA, 32'h0000_00A5);
    repeat (2) @(posedge pclk);
    `CHK("p7 analog", 8'h0F, analog_input_pin)
    `CHK("p7 oe", 8'hF0, p7_pin_oe)
    `CHK("p7 out", 8'hA0, p7_pin_out & 8'hF0)
    rd_chk(OFS_P7_DATA, 32'h0000_00A0);
    // shared port 8 pin
    p8_pin_in <= 2'h1;
    wr(OFS_P8_MODE, 32'h0000_0001);
    repeat (6) @(posedge pclk);
    `CHK("irq8", 1'b1, ext_irq8_pin)
    `CHK("uart3 rx", 1'b1, uart3_rx_pin)
    wr(OFS_P8_MODE, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    `CHK("irq8 off", 1'b0, ext_irq8_pin)
    `CHK("uart3 rx off", 1'b0, uart3_rx_pin)
    wr(OFS_P8_DIR, 32'h0000_0000);
    wr(OFS_P8_DATA, 32'h0000_0002);
    wr(OFS_P8_OD, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    `CHK("p8 od oe", 2'h1, p8_pin_oe)
    `CHK("p8 od out", 2'h0, p8_pin_out)
    rd_chk(OFS_P8_DATA, 32'h0000_0002);
    // port 9 pin 1 select codes
    p9_pin_in <= 16'h0002;
    p9_periph_oe <= 16'h0002;
    p9_periph_out <= 16'h0002;
    wr(OFS_P9_MODE, 32'h0000_0002);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_P9_FSEL, c[0] ? 32'h0000_0002 : 32'h0000_0000);
      wr(OFS_P9_XSEL, c[1] ? 32'h0000_0002 : 32'h0000_0000);
      repeat (6) @(posedge pclk);
      `CHK("uart1 rx", c == 2, uart1_rx_pin)
      `CHK("key ret7", c == 1, key_return7_pin)
      if (c != 0) `CHK("p9 pin1 oe", c == 3, p9_pin_oe[1])
    end
    // separate address bus setup
    address_bus_lines <= 16'hBEEF;
    wr(OFS_P9_FSEL, 32'h0000_0000);
    wr(OFS_P9_XSEL, 32'h0000_0000);
    wr(OFS_P9_MODE, 32'h0000_FFFF);
    repeat (2) @(posedge pclk);
    `CHK("addr bus", 1'b1, addr_bus_active)
    `CHK("addr pins", 16'hBEEF, p9_pin_out)
    rd_chk(OFS_STATUS, 32'h0000_0001);
    rd_chk(OFS_P9_MODE_H, 32'h0000_00FF);
    wr(OFS_P9_MODE_H, 32'h0000_007F, 4'h1);
    repeat (2) @(posedge pclk);
    `CHK("addr bus off", 1'b0, addr_bus_active)
    // unmapped offset
    xfer(8'h1C, 1'b1, 32'hFFFF_FFFF, 4'hF, r, e);
    `CHK("err wr", 1'b1, e)
    xfer(8'h1C, 1'b0, 32'h0000_0000, 4'h0, r, e);
    `CHK("err rd", 1'b1, e)
    `CHK("err data", 32'h0000_0000, r)
    tally_and_finish();
  end
endmodule
